// [design/uls_pkg.sv]
/*
  constants, field layout and receiver states of the line-status logic.
  assumes one system clock, a 16x baud tick from outside and a plain
  register port with read data one cycle after the strobe.
*/
// Operation
// - fifo mode: rx_fifo_error set while any fifo entry holds an error.
// - line_state read clears rx_fifo_error only if only the top entry erred.
// - fifo mode: tx_all_empty set when shifter and tx fifo are empty.
// - no fifo: tx_all_empty set when holding and shift registers are empty.
// - tx_hold_empty set once the last queued byte moved into the shifter.
// - holding-empty interrupt when enabled and threshold mode off.
// - threshold and fifo mode: bit 5 shows tx fifo full; irq uses threshold.
// - plain mode: break_flag when input low longer than one character time.
// - infrared mode: break_flag when pulsed low longer than one character.
// - a break loads exactly one all-zero character.
// - fifo mode: break shown at fifo top; otherwise at once, held till read.
// - framing_error set when no valid stop bit is found.
// - after a framing error the bad stop bit starts the next character, unless the whole frame was low.
// - a break also sets framing_error and parity_error.
// - parity_error set on mismatch only while parity_on is set.
// - fifo mode: parity and framing errors shown when char reaches top.
// - line_state read clears framing, parity, overrun and break; a set in the same cycle wins.
// - no fifo: overrun when a new char overwrites an unread rx_buffer.
// - fifo mode: overrun when fifo full; keep fifo, drop the new char.
// - data_ready high while a character waits in rx_buffer or fifo.
// - data_ready drops on rx_buffer read, or when the fifo empties.
// - modem_ctrl bit 6 selects infrared mode when set.
package uls_pkg;
  // register byte addresses
  localparam logic [31:0] ADDR_RX_TX = 32'h5000_1100;
  localparam logic [31:0] ADDR_MODEM_CTRL = 32'h5000_1110;
  localparam logic [31:0] ADDR_LINE_STATE = 32'h5000_1114;
  localparam logic [31:0] ADDR_MODEM_STATE = 32'h5000_1118;
  localparam logic [31:0] ADDR_CFG = 32'h5000_1140;

  // line_state bit positions
  localparam int LS_DR = 0;
  localparam int LS_OE = 1;
  localparam int LS_PE = 2;
  localparam int LS_FE = 3;
  localparam int LS_BI = 4;
  localparam int LS_THRE = 5;
  localparam int LS_TEMT = 6;
  localparam int LS_RFE = 7;

  // configuration register fields
  localparam int CFG_FIFO_EN = 0;
  localparam int CFG_THRE_MODE = 1;
  localparam int CFG_TX_THR = 2;
  localparam int CFG_THRE_IRQ = 4;
  localparam int CFG_WLEN = 8;
  localparam int CFG_STOP2 = 10;
  localparam int CFG_PAR_ON = 11;
  localparam int CFG_PAR_EVEN = 12;
  localparam logic [15:0] CFG_MASK = 16'h1f1f;
  localparam logic [15:0] CFG_RESET = 16'h0000;
  localparam int MC_IR_BIT = 6;
  localparam logic MC_IR_RESET = 1'h0;

  // fifo geometry and entry layout
  localparam int DATA_W = 8;
  localparam int ENT_W = 11;
  localparam int ENT_PE = 8;
  localparam int ENT_FE = 9;
  localparam int ENT_BI = 10;
  localparam logic [4:0] FIFO_DEPTH = 5'h10;
  localparam logic [3:0][4:0] TX_LEVELS = {5'h08, 5'h04, 5'h02, 5'h00};

  // receiver timing: sample points in 16x ticks, frame base in bits
  localparam logic [3:0] SAMP_MID = 4'h7;
  localparam logic [3:0] SAMP_LAST = 4'hf;
  localparam logic [3:0] FRAME_BASE = 4'h6;

  typedef enum logic [2:0] {
    uls_st_idle = 3'b000,
    uls_st_start = 3'b001,
    uls_st_data = 3'b010,
    uls_st_parity = 3'b011,
    uls_st_stop = 3'b100,
    uls_st_brkchk = 3'b101,
    uls_st_break = 3'b110
  } uls_rx_e;
endpackage : uls_pkg

// [design/uls_top.sv]
/*
  line-status logic: serial receiver with break detection, receive and
  transmit queues, line_state flags and holding-empty interrupt.
  assumes i_baud16 pulses 16 times per bit, the transmit shifter takes
  bytes with i_tx_take and reports i_tx_shift_empty.
*/
`timescale 1ns/10ps
module uls_top (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic [31:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [15:0] o_rdata,
  input wire logic i_baud16,
  input wire logic i_sin,
  input wire logic i_sir_in,
  input wire logic [7:0] i_modem_state,
  input wire logic i_tx_take,
  input wire logic i_tx_shift_empty,
  output logic [7:0] o_tx_data,
  output logic o_tx_valid,
  output logic o_thre_irq
);
  typedef struct packed {
    uls_pkg::uls_rx_e st;
    logic [3:0] samp;
    logic [2:0] bitn;
    logic [7:0] shf;
    logic par_bad;
    logic low_seen;
    logic [3:0] zrun;
    logic [15:0][10:0] rx_mem;
    logic [3:0] rx_rd;
    logic [4:0] rx_cnt;
    logic [15:0][7:0] tx_mem;
    logic [3:0] tx_rd;
    logic [4:0] tx_cnt;
    logic oe;
    logic pe;
    logic fe;
    logic bi;
    logic [15:0] cfg;
    logic ir_mode;
    logic [15:0] rdata;
  } uls_state_s;

  uls_state_s r;
  uls_state_s next_r;

  logic fifo_en;
  logic thr_mode;
  logic [4:0] cap;
  logic [1:0] wlen;
  logic [3:0] char_bits;
  logic [3:0] body_bits;
  logic [7:0] rx_dat;
  logic v;
  logic [3:0] zn;
  logic lsr_rd;
  logic rx_rd_acc;
  logic tx_wr_acc;
  logic push;
  logic brk_push;
  logic overrun;
  logic top_changed;
  logic [10:0] push_ent;
  logic [15:0] err_vec;
  logic rfe;
  logic temt;
  logic thre;
  logic [15:0] lsr_value;
  logic [4:0] tx_lvl;

  // mode decode from configuration
  assign fifo_en = r.cfg[uls_pkg::CFG_FIFO_EN];
  assign thr_mode = r.cfg[uls_pkg::CFG_THRE_MODE] & fifo_en;
  assign cap = fifo_en ? uls_pkg::FIFO_DEPTH : 5'h01;
  assign wlen = r.cfg[uls_pkg::CFG_WLEN +: 2];
  // bits up to the first stop, and whole character time
  assign body_bits = uls_pkg::FRAME_BASE + {2'h0, wlen} +
                     {3'h0, r.cfg[uls_pkg::CFG_PAR_ON]} + 4'h1;
  assign char_bits = body_bits + {3'h0, r.cfg[uls_pkg::CFG_STOP2]};
  // shorter words sit in the high end of the shifter
  assign rx_dat = r.shf >> (2'h3 - wlen);

  // bit value at a sample: ir counts any low pulse inside the bit window
  assign v = r.ir_mode ? ~(r.low_seen | ~i_sir_in) : i_sin;
  assign zn = v ? 4'h0 : ((r.zrun == 4'hf) ? r.zrun : r.zrun + 4'h1);

  // register port strobes
  assign lsr_rd = i_rd && (i_addr == uls_pkg::ADDR_LINE_STATE);
  assign rx_rd_acc = i_rd && (i_addr == uls_pkg::ADDR_RX_TX) &&
                     (r.rx_cnt != 5'h00);
  assign tx_wr_acc = i_wr && (i_addr == uls_pkg::ADDR_RX_TX) &&
                     (r.tx_cnt != cap);

  // error summary over the live entries of the receive queue
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++) begin : g_err
      logic [3:0] off;
      assign off = 4'(gi) - r.rx_rd;
      assign err_vec[gi] = ({1'b0, off} < r.rx_cnt) &&
                           (|r.rx_mem[gi][uls_pkg::ENT_BI:uls_pkg::ENT_PE]);
    end
  endgenerate
  assign rfe = fifo_en && (err_vec != 16'h0000);

  // transmit side status
  assign temt = (r.tx_cnt == 5'h00) && i_tx_shift_empty;
  assign thre = thr_mode ? (r.tx_cnt == uls_pkg::FIFO_DEPTH)
                         : (r.tx_cnt == 5'h00);
  assign tx_lvl = uls_pkg::TX_LEVELS[r.cfg[uls_pkg::CFG_TX_THR +: 2]];
  assign o_thre_irq = r.cfg[uls_pkg::CFG_THRE_IRQ] &&
                      (thr_mode ? (r.tx_cnt <= tx_lvl)
                                : (r.tx_cnt == 5'h00));
  assign o_tx_valid = (r.tx_cnt != 5'h00);
  assign o_tx_data = r.tx_mem[r.tx_rd];
  assign o_rdata = r.rdata;

  // values before any read clears them
  assign lsr_value = {8'h00, rfe, temt, thre, r.bi, r.fe, r.pe, r.oe,
                      (r.rx_cnt != 5'h00)};

  // all next-state logic
  always_comb begin
    next_r = r;
    push = 1'b0;
    brk_push = 1'b0;
    overrun = 1'b0;
    top_changed = 1'b0;
    push_ent = '0;

    // receiver: 16x sampled, mid-bit decisions
    next_r.low_seen = r.low_seen | ~i_sir_in;
    case (r.st)
      uls_pkg::uls_st_idle: begin
        next_r.zrun = 4'h0;
        next_r.samp = 4'h0;
        if (r.ir_mode ? ~i_sir_in : ~i_sin) begin
          next_r.st = uls_pkg::uls_st_start;
          next_r.low_seen = 1'b1;
        end
      end
      uls_pkg::uls_st_start: begin
        if (i_baud16) begin
          next_r.samp = r.samp + 4'h1;
          if (r.samp == uls_pkg::SAMP_MID) begin
            next_r.samp = 4'h0;
            next_r.low_seen = 1'b0;
            // a start glitch returns to idle
            next_r.st = v ? uls_pkg::uls_st_idle : uls_pkg::uls_st_data;
            next_r.bitn = 3'h0;
            next_r.zrun = zn;
          end
        end
      end
      default: begin
        if (i_baud16) begin
          next_r.samp = r.samp + 4'h1;
          if (r.samp == uls_pkg::SAMP_LAST) begin
            next_r.low_seen = 1'b0;
            next_r.zrun = zn;
            case (r.st)
              uls_pkg::uls_st_data: begin
                next_r.shf = {v, r.shf[7:1]};
                next_r.bitn = r.bitn + 3'h1;
                if (r.bitn == {1'b1, wlen}) begin
                  next_r.par_bad = 1'b0;
                  next_r.st = r.cfg[uls_pkg::CFG_PAR_ON] ?
                              uls_pkg::uls_st_parity : uls_pkg::uls_st_stop;
                end
              end
              uls_pkg::uls_st_parity: begin
                // even: ones count with parity bit must be even
                next_r.par_bad = (^rx_dat ^ v) ^
                                 ~r.cfg[uls_pkg::CFG_PAR_EVEN];
                next_r.st = uls_pkg::uls_st_stop;
              end
              uls_pkg::uls_st_stop: begin
                push_ent = {1'b0, ~v, r.par_bad, rx_dat};
                if (v) begin
                  push = 1'b1;
                  next_r.st = uls_pkg::uls_st_idle;
                end else if (zn == body_bits) begin
                  // whole frame low so far: wait one more bit, two with two stop bits
                  next_r.st = uls_pkg::uls_st_brkchk;
                end else begin
                  push = 1'b1;
                  next_r.st = uls_pkg::uls_st_data;
                  next_r.bitn = 3'h0;
                end
              end
              uls_pkg::uls_st_brkchk: begin
                if (v) begin
                  push = 1'b1;
                  push_ent = {1'b0, 1'b1, r.par_bad, rx_dat};
                  next_r.st = uls_pkg::uls_st_idle;
                end else if (zn > char_bits) begin
                  push = 1'b1;
                  brk_push = 1'b1;
                  push_ent = {3'b111, 8'h00};
                  next_r.st = uls_pkg::uls_st_break;
                end
              end
              uls_pkg::uls_st_break: begin
                // no further characters until the line recovers
                if (v) begin
                  next_r.st = uls_pkg::uls_st_idle;
                end
              end
              default: begin
                next_r.st = uls_pkg::uls_st_idle;
              end
            endcase
          end
        end
      end
    endcase

    // line_state read: clear sticky flags and top entry errors
    if (lsr_rd) begin
      next_r.oe = 1'b0;
      next_r.pe = 1'b0;
      next_r.fe = 1'b0;
      next_r.bi = 1'b0;
      if (r.rx_cnt != 5'h00) begin
        next_r.rx_mem[r.rx_rd][uls_pkg::ENT_BI:uls_pkg::ENT_PE] = 3'h0;
      end
    end

    // receive queue: pop by rx_buffer read, push by receiver
    if (rx_rd_acc) begin
      next_r.rx_rd = r.rx_rd + 4'h1;
      next_r.rx_cnt = r.rx_cnt - 5'h01;
      top_changed = (r.rx_cnt > 5'h01);
    end
    if (push) begin
      if ((r.rx_cnt != cap) || rx_rd_acc) begin
        next_r.rx_mem[r.rx_rd + r.rx_cnt[3:0]] = push_ent;
        next_r.rx_cnt = next_r.rx_cnt + 5'h01;
        top_changed = top_changed || (next_r.rx_cnt == 5'h01);
      end else if (fifo_en) begin
        overrun = 1'b1;
      end else begin
        overrun = 1'b1;
        next_r.rx_mem[r.rx_rd] = push_ent;
        top_changed = 1'b1;
      end
    end
    if (overrun) begin
      next_r.oe = 1'b1;
    end
    // flags of the new top entry; set wins over the read clear
    if (top_changed) begin
      next_r.pe = next_r.pe | next_r.rx_mem[next_r.rx_rd][uls_pkg::ENT_PE];
      next_r.fe = next_r.fe | next_r.rx_mem[next_r.rx_rd][uls_pkg::ENT_FE];
      next_r.bi = next_r.bi |
                  next_r.rx_mem[next_r.rx_rd][uls_pkg::ENT_BI];
    end

    // transmit queue: write when room, drain to the shifter
    if (tx_wr_acc) begin
      next_r.tx_mem[r.tx_rd + r.tx_cnt[3:0]] = i_wdata[7:0];
      next_r.tx_cnt = next_r.tx_cnt + 5'h01;
    end
    if (i_tx_take && (r.tx_cnt != 5'h00)) begin
      next_r.tx_rd = r.tx_rd + 4'h1;
      next_r.tx_cnt = next_r.tx_cnt - 5'h01;
    end

    // control writes; a fifo mode change flushes both queues
    if (i_wr && (i_addr == uls_pkg::ADDR_CFG)) begin
      next_r.cfg = i_wdata & uls_pkg::CFG_MASK;
      if (i_wdata[uls_pkg::CFG_FIFO_EN] != fifo_en) begin
        next_r.rx_cnt = 5'h00;
        next_r.rx_rd = 4'h0;
        next_r.tx_cnt = 5'h00;
        next_r.tx_rd = 4'h0;
      end
    end
    if (i_wr && (i_addr == uls_pkg::ADDR_MODEM_CTRL)) begin
      next_r.ir_mode = i_wdata[uls_pkg::MC_IR_BIT];
    end

    // read data mux, valid the cycle after the strobe
    next_r.rdata = 16'h0000;
    if (i_rd) begin
      case (i_addr)
        uls_pkg::ADDR_RX_TX: begin
          if (r.rx_cnt != 5'h00) begin
            next_r.rdata = {8'h00, r.rx_mem[r.rx_rd][7:0]};
          end
        end
        uls_pkg::ADDR_MODEM_CTRL: begin
          next_r.rdata = {9'h000, r.ir_mode, 6'h00};
        end
        uls_pkg::ADDR_LINE_STATE: begin
          next_r.rdata = lsr_value;
        end
        uls_pkg::ADDR_MODEM_STATE: begin
          next_r.rdata = {8'h00, i_modem_state};
        end
        uls_pkg::ADDR_CFG: begin
          next_r.rdata = r.cfg;
        end
        default: begin
          next_r.rdata = 16'h0000;
        end
      endcase
    end
  end

  // state register, synchronous reset
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      r <= '0;
      r.cfg <= uls_pkg::CFG_RESET;
      r.ir_mode <= uls_pkg::MC_IR_RESET;
    end else begin
      r <= next_r;
    end
  end

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_resetn);

  a_dr_shown: assert property (
    (lsr_rd && (r.rx_cnt != 5'h00)) |=> o_rdata[uls_pkg::LS_DR])
    else $error("data ready not reported");
  a_temt_shown: assert property (
    (lsr_rd && (r.tx_cnt == 5'h00) && i_tx_shift_empty)
    |=> o_rdata[uls_pkg::LS_TEMT])
    else $error("transmitter empty not reported");
  a_thre_full: assert property (
    (lsr_rd && thr_mode && (r.tx_cnt == uls_pkg::FIFO_DEPTH))
    |=> o_rdata[uls_pkg::LS_THRE])
    else $error("fifo full not shown on bit 5");
  a_oe_sticky: assert property (
    overrun |=> r.oe ##1 (r.oe || $past(lsr_rd)))
    else $error("overrun flag lost");
  a_fifo_keep: assert property (
    (overrun && fifo_en) |=> (r.rx_cnt == $past(r.rx_cnt)))
    else $error("fifo contents changed on overrun");
  a_buf_overwrite: assert property (
    (overrun && !fifo_en) |=> (r.rx_cnt == 5'h01) &&
    (r.rx_mem[r.rx_rd][7:0] == $past(push_ent[7:0])))
    else $error("buffer not overwritten");
  a_break_char: assert property (
    brk_push |-> (push_ent == {3'b111, 8'h00}) &&
    $past(r.st) != uls_pkg::uls_st_break)
    else $error("break character malformed");
  a_break_once: assert property (
    brk_push |=> !brk_push throughout (r.st == uls_pkg::uls_st_break))
    else $error("second break character");
  a_parity_off: assert property (
    (push && !brk_push && !r.cfg[uls_pkg::CFG_PAR_ON]) |-> !push_ent[8])
    else $error("parity error without parity");
  a_rfe_nofifo: assert property (
    (lsr_rd && !fifo_en) |=> !o_rdata[uls_pkg::LS_RFE])
    else $error("fifo error outside fifo mode");
  a_lsr_clear: assert property (
    (lsr_rd && !overrun && !top_changed) |=> !r.oe && !r.fe && !r.pe)
    else $error("flags not cleared by read");
endmodule : uls_top

// [verification/testbench.sv]
/*
  self-checking bench of the line-status logic, register port tasks.
  assumes the remote sender model and the design package are compiled.
*/
`timescale 1ns/10ps
module testbench;
  localparam logic [31:0] A_RX = uls_pkg::ADDR_RX_TX;
  localparam logic [31:0] A_MC = uls_pkg::ADDR_MODEM_CTRL;
  localparam logic [31:0] A_LS = uls_pkg::ADDR_LINE_STATE;
  localparam logic [31:0] A_MS = uls_pkg::ADDR_MODEM_STATE;
  localparam logic [31:0] A_CF = uls_pkg::ADDR_CFG;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [31:0] addr = 32'h0;
  logic [15:0] wdata = 16'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [15:0] rdata;
  logic baud16;
  logic sin;
  logic sir_in;
  logic [7:0] modem_state = 8'ha5;
  logic tx_take = 1'b0;
  logic tx_shift_empty = 1'b1;
  logic [7:0] tx_data;
  logic tx_valid;
  logic thre_irq;
  int err_total = 0;
  int n_tests = 0;

  // 50 mhz clock
  always #10 clk = ~clk;

  uls_top i_dut (
    .i_clk(clk), .i_resetn(resetn), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_baud16(baud16),
    .i_sin(sin), .i_sir_in(sir_in), .i_modem_state(modem_state),
    .i_tx_take(tx_take), .i_tx_shift_empty(tx_shift_empty),
    .o_tx_data(tx_data), .o_tx_valid(tx_valid), .o_thre_irq(thre_irq)
  );

  uls_remote u_remote (
    .i_clk(clk), .i_resetn(resetn), .o_baud16(baud16), .o_sin(sin),
    .o_sir_in(sir_in)
  );

  // compare and count
  task automatic chk(input string nm, input logic [15:0] got,
      input logic [15:0] e);
    n_tests++;
    if (got !== e) begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, e, got);
    end
  endtask : chk

  // one-cycle write strobe
  task automatic wr_reg(input logic [31:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  // read strobe, data taken in the following cycle only
  task automatic ck(input string nm, input logic [31:0] a,
      input logic [15:0] e);
    logic [15:0] v;
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
    chk(nm, v, e);
  endtask : ck

  // settled level of the holding-empty interrupt
  task automatic ck_irq(input logic e);
    #1 chk("irq", {15'h0, thre_irq}, {15'h0, e});
  endtask : ck_irq

  // shifter takes the queue top for one cycle
  task automatic pop(input logic [7:0] e);
    #1 chk("txd", {8'h0, tx_data}, {8'h0, e});
    @(posedge clk);
    tx_take <= 1'b1;
    @(posedge clk);
    tx_take <= 1'b0;
  endtask : pop

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_of_test

  // hang guard, well past the expected 11k cycles
  initial begin
    repeat (60000) @(posedge clk);
    err_total++;
    end_of_test();
  end

  // test sequence
  initial begin
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    ck("ls", A_LS, 16'h0060);
    ck("ms", A_MS, 16'h00a5);
    ck("unmapped", 32'h5000_1180, 16'h0000);
    wr_reg(A_LS, 16'hffff);
    ck("ls_ro", A_LS, 16'h0060);
    $display("test reset done");
    // no fifo: second char overwrites the first
    wr_reg(A_CF, 16'h0300);
    u_remote.send(8'h41, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    u_remote.send(8'h42, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    ck("ls_oe", A_LS, 16'h0063);
    ck("ls_clr", A_LS, 16'h0061);
    ck("rx", A_RX, 16'h0042);
    ck("ls_dr", A_LS, 16'h0060);
    $display("test overrun done");
    // even parity, one bad then one good
    wr_reg(A_CF, 16'h1b00);
    u_remote.send(8'h5a, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
    ck("ls_pe", A_LS, 16'h0065);
    ck("rx", A_RX, 16'h005a);
    u_remote.send(8'h5b, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
    ck("ls_ok", A_LS, 16'h0061);
    ck("rx", A_RX, 16'h005b);
    // odd parity: an even-parity bit on the line is a mismatch
    wr_reg(A_CF, 16'h0b00);
    u_remote.send(8'h5c, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
    ck("ls_odd", A_LS, 16'h0065);
    ck("rx", A_RX, 16'h005c);
    $display("test parity done");
    // fifo: bad stop serves as the next start bit
    wr_reg(A_CF, 16'h0301);
    u_remote.send(8'hc3, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
    u_remote.send(8'h3c, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
    ck("ls_fe", A_LS, 16'h00e9);
    ck("ls_rfe", A_LS, 16'h0061);
    ck("rx", A_RX, 16'h00c3);
    ck("rx", A_RX, 16'h003c);
    ck("ls_dr", A_LS, 16'h0060);
    $display("test framing done");
    // fifo: break behind a good char shows only at the top
    u_remote.send(8'h11, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    u_remote.brk(30, 1'b0);
    ck("ls_hid", A_LS, 16'h00e1);
    ck("rx", A_RX, 16'h0011);
    ck("ls_bi", A_LS, 16'h00fd);
    ck("ls_rfe", A_LS, 16'h0061);
    ck("rx", A_RX, 16'h0000);
    ck("ls_one", A_LS, 16'h0060);
    $display("test fifo break done");
    // infrared line, no fifo: char then break shown at once
    wr_reg(A_MC, 16'h0040);
    ck("mc", A_MC, 16'h0040);
    wr_reg(A_CF, 16'h0300);
    u_remote.send(8'h96, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
    ck("rx_ir", A_RX, 16'h0096);
    u_remote.brk(30, 1'b1);
    ck("ls_irbi", A_LS, 16'h007d);
    ck("rx", A_RX, 16'h0000);
    wr_reg(A_MC, 16'h0000);
    $display("test infrared done");
    // fifo full: the 17th char is dropped
    wr_reg(A_CF, 16'h0301);
    for (int i = 1; i < 18; i++) begin
      u_remote.send(8'(i), 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    end
    ck("ls_oe", A_LS, 16'h0063);
    for (int i = 1; i < 17; i++) begin
      ck("rx", A_RX, 16'(i));
    end
    ck("ls_dr", A_LS, 16'h0060);
    $display("test fifo overrun done");
    // holding register path with the interrupt enabled
    wr_reg(A_CF, 16'h0310);
    ck_irq(1'b1);
    wr_reg(A_RX, 16'h00a7);
    ck_irq(1'b0);
    ck("ls_full", A_LS, 16'h0000);
    chk("txv", {15'h0, tx_valid}, 16'h0001);
    pop(8'ha7);
    tx_shift_empty <= 1'b0;
    ck("ls_shift", A_LS, 16'h0020);
    ck_irq(1'b1);
    @(posedge clk);
    tx_shift_empty <= 1'b1;
    ck("ls_idle", A_LS, 16'h0060);
    wr_reg(A_CF, 16'h0300);
    ck_irq(1'b0);
    $display("test holding done");
    // threshold mode: bit 5 shows full, irq at two entries
    wr_reg(A_CF, 16'h0317);
    for (int i = 0; i < 16; i++) begin
      wr_reg(A_RX, 16'(i + 16));
    end
    ck("ls_txfull", A_LS, 16'h0020);
    ck_irq(1'b0);
    for (int i = 0; i < 15; i++) begin
      pop(8'(i + 16));
    end
    ck("ls_txone", A_LS, 16'h0000);
    ck_irq(1'b1);
    pop(8'h1f);
    ck("ls_txemp", A_LS, 16'h0040);
    chk("txv", {15'h0, tx_valid}, 16'h0000);
    $display("test threshold done");
    end_of_test();
  end
endmodule : testbench

// [verification/uls_remote.sv]
/*
  remote serial sender model: 16x baud tick, plain line and infrared line.
  assumes the bench calls send and brk just after a rising clock edge.
*/
`timescale 1ns/10ps
module uls_remote (
  input wire logic i_clk,
  input wire logic i_resetn,
  output logic o_baud16,
  output logic o_sin,
  output logic o_sir_in
);
  logic tick;

  // tick every second clock keeps frames short
  always_ff @(posedge i_clk) begin
    tick <= i_resetn & ~tick;
  end
  assign o_baud16 = tick;

  // both lines idle high between frames
  initial begin
    o_sin = 1'b1;
    o_sir_in = 1'b1;
  end

  // one bit of 16 ticks; an infrared zero is a short low pulse only
  task automatic bit_out(input logic v, input logic ir);
    for (int t = 0; t < 16; t++) begin
      @(posedge i_clk iff tick);
      o_sin <= ir | v;
      o_sir_in <= ~(ir & ~v & (t < 3));
    end
  endtask : bit_out

  // one 8-bit frame; a bad stop doubles as the next start
  task automatic send(input logic [7:0] d, input logic par,
      input logic bad_par, input logic bad_stop, input logic no_start,
      input logic ir);
    if (!no_start) bit_out(1'b0, ir);
    for (int i = 0; i < 8; i++) bit_out(d[i], ir);
    if (par) bit_out(^d ^ bad_par, ir);
    bit_out(~bad_stop, ir);
  endtask : send

  // line held at zero for n bit times, then two idle bits
  task automatic brk(input int n, input logic ir);
    for (int i = 0; i < n; i++) bit_out(1'b0, ir);
    bit_out(1'b1, ir);
    bit_out(1'b1, ir);
  endtask : brk
endmodule : uls_remote
